// file: rtl/jtag_secure_programming_port.sv
// Purpose: Test access port with secure in-system programming
// Assumes: Test pins are sampled by clk_i, far faster than the test clock
// Notes: Decrypted data never reaches the test data output
`timescale 1ns/1ps
`include "jsp_params.svh"
module jtag_secure_programming_port
  import jsp_pkg::*;
#(
  parameter int ADDR_W = 16
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic trst_n_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  input wire logic [`BLK_W-1:0] nv_key_i,
  input wire logic fabric_programmed_i,
  input wire logic osc_run_i,
  input wire logic osc_tick_i,
  input wire logic io_in_i,
  input wire logic user_tdo_i,
  input wire logic [`BLK_W-`TAG_W-1:0] mem_rdata_i,
  output logic io_en_o,
  output logic pump_clk_o,
  output logic mem_wr_o,
  output logic [1:0] mem_target_o,
  output logic [ADDR_W-1:0] mem_addr_o,
  output logic [`BLK_W-`TAG_W-1:0] mem_wdata_o,
  output logic user_tdi_o,
  output logic user_capture_o,
  output logic user_shift_o,
  output logic user_update_o
);
  localparam int PW = `BLK_W - `TAG_W;
  localparam logic [`ID_W-1:0] ID_VALUE = {`ID_VERSION, `ID_PART, `ID_MAKER, 1'b1};

  // ----------------------------------------
  // Pin synchronisers: bit 0 reset, 1 clock, 2 mode, 3 data, 4 oscillator
  // ----------------------------------------
  logic [4:0] s1_q, s2_q;
  logic tckp_q, rise, fall, trst_ok, tms_s, tdi_s, osc_s;
  always_ff @(posedge clk_i)
  begin
    // Pulled-up pins start as ones; the unpulled test clock starts low, so no false edge
    if (!rst_n_i)
    begin
      s1_q <= 5'h1D;
      s2_q <= 5'h1D;
      tckp_q <= 1'b0;
    end
    else if (ce_i)
    begin
      s1_q <= {osc_run_i, tdi_i, tms_i, tck_i, trst_n_i};
      s2_q <= s1_q;
      tckp_q <= s2_q[1];
    end
  end
  assign trst_ok = s2_q[0];
  assign tms_s = s2_q[2];
  assign tdi_s = s2_q[3];
  assign osc_s = s2_q[4];
  assign rise = ce_i & s2_q[1] & ~tckp_q;
  assign fall = ce_i & ~s2_q[1] & tckp_q;

  // ----------------------------------------
  // Port state machine
  // ----------------------------------------
  function automatic tap_state_t tap_next(input tap_state_t s, input logic m);
    case (s)
      st_tlr: return m ? st_tlr : st_rti;
      st_rti: return m ? st_sel_dr : st_rti;
      st_sel_dr: return m ? st_sel_ir : st_cap_dr;
      st_cap_dr: return m ? st_ex1_dr : st_sh_dr;
      st_sh_dr: return m ? st_ex1_dr : st_sh_dr;
      st_ex1_dr: return m ? st_up_dr : st_pa_dr;
      st_pa_dr: return m ? st_ex2_dr : st_pa_dr;
      st_ex2_dr: return m ? st_up_dr : st_sh_dr;
      st_up_dr: return m ? st_sel_dr : st_rti;
      st_sel_ir: return m ? st_tlr : st_cap_ir;
      st_cap_ir: return m ? st_ex1_ir : st_sh_ir;
      st_sh_ir: return m ? st_ex1_ir : st_sh_ir;
      st_ex1_ir: return m ? st_up_ir : st_pa_ir;
      st_pa_ir: return m ? st_ex2_ir : st_pa_ir;
      st_ex2_ir: return m ? st_up_ir : st_sh_ir;
      st_up_ir: return m ? st_sel_dr : st_rti;
      default: return st_tlr;
    endcase
  endfunction

  tap_state_t tap_q, tap_d;
  always_comb
  begin
    tap_d = tap_q;
    // Test reset needs no test clock edge to take effect
    if (!trst_ok)
      tap_d = st_tlr;
    else if (rise)
      tap_d = tap_next(tap_q, tms_s);
  end
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      tap_q <= st_tlr;
    else if (ce_i)
      tap_q <= tap_d;
  end

  // ----------------------------------------
  // Instruction, data path and programming control
  // ----------------------------------------
  logic [`IR_W-1:0] ir_q, ir_d, irs_q, irs_d;
  logic [`BLK_W-1:0] dr_q, dr_d;
  logic tdo_d, oe_d, is_prog, is_ver, is_user, start, tag_ok;
  logic prog_q, prog_d, fab_q, fab_d, wrote_q, wrote_d, abort_q, abort_d;
  logic auth_fail_q, auth_fail_d, ver_fail_q, ver_fail_d, osc_fail_q, osc_fail_d;
  logic programmed_q, programmed_d, init_q, init_d, io_en_d, wr_d;
  logic [1:0] tgt_d;
  logic [ADDR_W-1:0] addr_d;
  logic [PW-1:0] wdata_d;
  logic [2:0] pcnt_q, pcnt_d;
  logic pump_d, aes_done;
  logic [`BLK_W-1:0] aes_out;
  int len;

  assign is_prog = (ir_q == `OP_PROG_FABRIC) || (ir_q == `OP_PROG_ROM) || (ir_q == `OP_PROG_FLASH);
  assign is_ver = (ir_q == `OP_VERIFY);
  assign is_user = (ir_q == `OP_USER);
  assign start = rise && tap_q == st_up_dr && (is_prog || is_ver) && !abort_q && osc_s;
  assign tag_ok = (aes_out[`BLK_W-1 -: `TAG_W] == `AUTH_TAG);

  always_comb
  begin
    ir_d = ir_q;
    irs_d = irs_q;
    dr_d = dr_q;
    tdo_d = tdo_o;
    oe_d = tdo_oe_o;
    prog_d = prog_q;
    fab_d = fab_q;
    wrote_d = wrote_q;
    abort_d = abort_q;
    auth_fail_d = auth_fail_q;
    ver_fail_d = ver_fail_q;
    osc_fail_d = osc_fail_q;
    programmed_d = programmed_q;
    init_d = 1'b1;
    tgt_d = mem_target_o;
    addr_d = mem_addr_o;
    wdata_d = mem_wdata_o;
    wr_d = 1'b0;
    case (ir_q)
      `OP_IDCODE: len = `ID_W;
      `OP_STATUS: len = `STAT_W;
      `OP_PROG_FABRIC, `OP_PROG_ROM, `OP_PROG_FLASH, `OP_VERIFY: len = `BLK_W;
      default: len = 1;
    endcase
    if (!init_q)
      programmed_d = fabric_programmed_i;
    if (rise)
      case (tap_q)
        st_cap_ir: irs_d = `IR_CAPTURE;
        st_sh_ir: irs_d = {tdi_s, irs_q[`IR_W-1:1]};
        st_cap_dr:
          case (ir_q)
            `OP_IDCODE: dr_d = {{(`BLK_W-`ID_W){1'b0}}, ID_VALUE};
            `OP_STATUS: dr_d = {{(`BLK_W-4){1'b0}}, osc_fail_q, ver_fail_q, auth_fail_q, programmed_q};
            `OP_SAMPLE: dr_d = {{(`BLK_W-1){1'b0}}, io_in_i & io_en_o};
            default: dr_d = '0;
          endcase
        st_sh_dr:
        begin
          dr_d = dr_q >> 1;
          dr_d[len-1] = tdi_s;
        end
        default: ;
      endcase
    if (fall)
    begin
      oe_d = (tap_q == st_sh_ir) || (tap_q == st_sh_dr);
      if (tap_q == st_sh_ir)
        tdo_d = irs_q[0];
      else if (tap_q == st_sh_dr)
        tdo_d = is_user ? user_tdo_i : dr_q[0];
    end
    // Leaving a session, by new instruction or port reset
    if ((rise && tap_q == st_up_ir) || tap_q == st_tlr)
    begin
      if (fab_q)
        programmed_d = wrote_q && !abort_q;
      fab_d = 1'b0;
      prog_d = 1'b0;
      ir_d = (tap_q == st_tlr) ? `OP_IDCODE : irs_q;
      if (tap_q != st_tlr && irs_q inside {`OP_PROG_FABRIC, `OP_PROG_ROM, `OP_PROG_FLASH, `OP_VERIFY})
      begin
        prog_d = (irs_q != `OP_VERIFY);
        fab_d = (irs_q == `OP_PROG_FABRIC);
        if (irs_q == `OP_PROG_FABRIC)
          programmed_d = 1'b0;
        if (irs_q == `OP_PROG_FABRIC) tgt_d = `TGT_FABRIC;
        if (irs_q == `OP_PROG_ROM) tgt_d = `TGT_ROM;
        if (irs_q == `OP_PROG_FLASH) tgt_d = `TGT_FLASH;
        addr_d = '0;
        wrote_d = 1'b0;
        abort_d = 1'b0;
        auth_fail_d = 1'b0;
        ver_fail_d = 1'b0;
        osc_fail_d = 1'b0;
      end
    end
    // Oscillator must run throughout programming
    if ((is_prog || is_ver) && prog_q | is_ver && !osc_s && !abort_q && tap_q != st_tlr)
    begin
      osc_fail_d = 1'b1;
      abort_d = 1'b1;
    end
    if (aes_done && !abort_q)
    begin
      if (!tag_ok)
      begin
        auth_fail_d = 1'b1;
        abort_d = 1'b1;
      end
      else
      begin
        addr_d = mem_addr_o + ADDR_W'(1);
        if (is_ver)
          ver_fail_d = ver_fail_q | (mem_rdata_i != aes_out[PW-1:0]);
        else
        begin
          wr_d = 1'b1;
          wdata_d = aes_out[PW-1:0];
          wrote_d = 1'b1;
        end
      end
    end
    io_en_d = programmed_d && !fab_d;
  end

  // Pump drive: high for two of every five oscillator ticks
  always_comb
  begin
    pcnt_d = pcnt_q;
    pump_d = pump_clk_o;
    if (!(prog_q && osc_s && !abort_q))
    begin
      pcnt_d = 3'h0;
      pump_d = 1'b0;
    end
    else if (osc_tick_i)
    begin
      pcnt_d = (pcnt_q == 3'(`PUMP_DIV - 1)) ? 3'h0 : pcnt_q + 3'h1;
      pump_d = (pcnt_d < 3'(`PUMP_HIGH));
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ir_q <= `OP_IDCODE;
      irs_q <= '0;
      dr_q <= '0;
      tdo_o <= 1'b1;
      tdo_oe_o <= 1'b0;
      {prog_q, fab_q, wrote_q, abort_q} <= 4'h0;
      {auth_fail_q, ver_fail_q, osc_fail_q} <= 3'h0;
      programmed_q <= 1'b0;
      init_q <= 1'b0;
      io_en_o <= 1'b0;
      mem_wr_o <= 1'b0;
      mem_target_o <= `TGT_FABRIC;
      mem_addr_o <= '0;
      mem_wdata_o <= '0;
      pcnt_q <= 3'h0;
      pump_clk_o <= 1'b0;
    end
    else if (ce_i)
    begin
      ir_q <= ir_d;
      irs_q <= irs_d;
      dr_q <= dr_d;
      tdo_o <= tdo_d;
      tdo_oe_o <= oe_d;
      {prog_q, fab_q, wrote_q, abort_q} <= {prog_d, fab_d, wrote_d, abort_d};
      {auth_fail_q, ver_fail_q, osc_fail_q} <= {auth_fail_d, ver_fail_d, osc_fail_d};
      programmed_q <= programmed_d;
      init_q <= init_d;
      io_en_o <= io_en_d;
      mem_wr_o <= wr_d;
      mem_target_o <= tgt_d;
      mem_addr_o <= addr_d;
      mem_wdata_o <= wdata_d;
      pcnt_q <= pcnt_d;
      pump_clk_o <= pump_d;
    end
  end

  aes128_decrypt u_aes (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .start_i(start),
    .key_i(nv_key_i),
    .data_i(dr_q),
    .busy_o(),
    .done_o(aes_done),
    .data_o(aes_out)
  );

  // User logic reaches the port through the shared data pins
  assign user_tdi_o = tdi_s;
  assign user_capture_o = rise && is_user && tap_q == st_cap_dr;
  assign user_shift_o = rise && is_user && tap_q == st_sh_dr;
  assign user_update_o = rise && is_user && tap_q == st_up_dr;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  trst_init_a: assert property (ce_i && !trst_ok |=> tap_q == st_tlr)
    else $error("test reset did not reset the port");
  io_hold_a: assert property (!programmed_q |-> !io_en_o)
    else $error("I/O enabled while unprogrammed");
  sample_quiet_a: assert property (rise && tap_q == st_cap_dr && ir_q == `OP_SAMPLE && !io_en_o |=> dr_q == '0)
    else $error("sample captured while unprogrammed");
  user_out_a: assert property (fall && tap_q == st_sh_dr && is_user |=> tdo_o == $past(user_tdo_i))
    else $error("user data not on output");
  id_load_a: assert property (rise && tap_q == st_cap_dr && ir_q == `OP_IDCODE |=> dr_q[`ID_W-1:0] == ID_VALUE)
    else $error("identity not captured");
  auth_reject_a: assert property (ce_i && aes_done && !abort_q && !tag_ok |=> !mem_wr_o && auth_fail_q && abort_q)
    else $error("bad block was committed");
  pump_gate_a: assert property ($rose(pump_clk_o) |-> $past(prog_q && osc_s))
    else $error("pump runs outside programming");
  io_release_a: assert property ($rose(io_en_o) |-> programmed_q && !fab_q)
    else $error("I/O released during fabric programming");
  tms_step_a: assert property (rise && trst_ok && tap_q == st_rti && tms_s |=> tap_q == st_sel_dr)
    else $error("mode select not followed");
endmodule

// file: common/jsp_params.svh
// Purpose: Constants of the secure test-port programming block
// Assumes: Included by the design files and by the bench
// Notes: Opcodes past the mandatory set, the identity fields and the
//        authentication tag are local choices
`ifndef JSP_PARAMS_SVH
`define JSP_PARAMS_SVH
// ----------------------------------------
// Instruction opcodes
// ----------------------------------------
`define IR_W 8
`define IR_CAPTURE 8'h01
`define OP_EXTEST 8'h00
`define OP_SAMPLE 8'h01
`define OP_IDCODE 8'h0F
`define OP_BYPASS 8'hFF
`define OP_PROG_FABRIC 8'h20
`define OP_PROG_ROM 8'h21
`define OP_PROG_FLASH 8'h22
`define OP_VERIFY 8'h23
`define OP_STATUS 8'h30
`define OP_USER 8'h40
// ----------------------------------------
// Data register layout
// ----------------------------------------
`define BLK_W 128
`define TAG_W 16
`define AUTH_TAG 16'h5AA5
`define ID_W 32
`define STAT_W 8
// Identity values are arbitrary
`define ID_VERSION 4'h1
`define ID_PART 16'h0123
`define ID_MAKER 11'h055
`define TGT_FABRIC 2'h0
`define TGT_ROM 2'h1
`define TGT_FLASH 2'h2
// ----------------------------------------
// Timing
// ----------------------------------------
`define OSC_MHZ 100
`define PUMP_MHZ 20
`define PUMP_DIV (`OSC_MHZ / `PUMP_MHZ)
`define PUMP_HIGH 2
`define AES_ROUNDS 10
`endif

// file: common/jsp_pkg.sv
// Purpose: Shared types of the secure test-port programming block
// Assumes: Nothing
// Notes: Codes follow Gray steps in the order the states are listed
package jsp_pkg;
  typedef enum logic [3:0] {
    st_tlr = 4'h0, st_rti = 4'h1, st_sel_dr = 4'h3, st_cap_dr = 4'h2,
    st_sh_dr = 4'h6, st_ex1_dr = 4'h7, st_pa_dr = 4'h5, st_ex2_dr = 4'h4,
    st_up_dr = 4'hC, st_sel_ir = 4'hD, st_cap_ir = 4'hF, st_sh_ir = 4'hE,
    st_ex1_ir = 4'hA, st_pa_ir = 4'hB, st_ex2_ir = 4'h9, st_up_ir = 4'h8
  } tap_state_t;
  typedef enum logic [1:0] {
    aes_idle = 2'h0, aes_kexp = 2'h1, aes_round = 2'h3
  } aes_state_t;
endpackage

// file: rtl/aes128_decrypt.sv
// Purpose: Iterative 128-bit AES inverse cipher, one round per cycle
// Assumes: Key and block are held by the caller only at start
// Notes: Key schedule is run forward, then unwound round by round
`timescale 1ns/1ps
`include "jsp_params.svh"
module aes128_decrypt
  import jsp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire logic [`BLK_W-1:0] key_i,
  input wire logic [`BLK_W-1:0] data_i,
  output logic busy_o,
  output logic done_o,
  output logic [`BLK_W-1:0] data_o
);
  // Rcon preceding 8'h01 so the first forward step lands on 8'h01
  localparam logic [7:0] RC_INIT = 8'h8D;

  function automatic logic [7:0] xt(input logic [7:0] a);
    return {a[6:0], 1'b0} ^ (a[7] ? 8'h1B : 8'h00);
  endfunction
  function automatic logic [7:0] gm(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] r;
    logic [7:0] p;
    r = 8'h00;
    p = a;
    for (int i = 0; i < 8; i++)
    begin
      if (b[i]) r = r ^ p;
      p = xt(p);
    end
    return r;
  endfunction
  // a^254 is the field inverse; zero maps to zero
  function automatic logic [7:0] ginv(input logic [7:0] a);
    logic [7:0] r;
    logic [7:0] p;
    r = 8'h01;
    p = a;
    for (int i = 1; i < 8; i++)
    begin
      p = gm(p, p);
      r = gm(r, p);
    end
    return r;
  endfunction
  function automatic logic [7:0] rl(input logic [7:0] x, input int n);
    logic [15:0] d;
    d = {x, x};
    return d[15-n -: 8];
  endfunction
  function automatic logic [7:0] sbox(input logic [7:0] a);
    logic [7:0] b;
    b = ginv(a);
    return b ^ rl(b, 1) ^ rl(b, 2) ^ rl(b, 3) ^ rl(b, 4) ^ 8'h63;
  endfunction
  function automatic logic [7:0] isbox(input logic [7:0] a);
    return ginv(rl(a, 1) ^ rl(a, 3) ^ rl(a, 6) ^ 8'h05);
  endfunction
  function automatic logic [31:0] subrot(input logic [31:0] w, input logic [7:0] rc);
    return {sbox(w[23:16]) ^ rc, sbox(w[15:8]), sbox(w[7:0]), sbox(w[31:24])};
  endfunction
  function automatic logic [127:0] kfwd(input logic [127:0] k, input logic [7:0] rc);
    logic [31:0] w0;
    logic [31:0] w1;
    logic [31:0] w2;
    w0 = k[127:96] ^ subrot(k[31:0], rc);
    w1 = k[95:64] ^ w0;
    w2 = k[63:32] ^ w1;
    return {w0, w1, w2, k[31:0] ^ w2};
  endfunction
  function automatic logic [127:0] kbwd(input logic [127:0] k, input logic [7:0] rc);
    logic [31:0] p3;
    p3 = k[31:0] ^ k[63:32];
    return {k[127:96] ^ subrot(p3, rc), k[95:64] ^ k[127:96], k[63:32] ^ k[95:64], p3};
  endfunction
  function automatic logic [127:0] iround(input logic [127:0] s, input logic [127:0] k, input logic last);
    logic [7:0] t [16];
    logic [127:0] o;
    for (int c = 0; c < 4; c++)
      for (int r = 0; r < 4; r++)
        t[r+4*c] = isbox(s[127-8*(r+4*((c-r+4)%4)) -: 8]) ^ k[127-8*(r+4*c) -: 8];
    for (int c = 0; c < 4; c++)
      for (int r = 0; r < 4; r++)
        o[127-8*(r+4*c) -: 8] = last ? t[r+4*c] :
          gm(t[4*c+r], 8'h0E) ^ gm(t[4*c+(r+1)%4], 8'h0B) ^
          gm(t[4*c+(r+2)%4], 8'h0D) ^ gm(t[4*c+(r+3)%4], 8'h09);
    return o;
  endfunction

  aes_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] rc_q, rc_d;
  logic [127:0] rk_q, rk_d, blk_q, blk_d, kn, kp;
  logic done_d;

  // ----------------------------------------
  // Round sequencing
  // ----------------------------------------
  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    rc_d = rc_q;
    rk_d = rk_q;
    blk_d = blk_q;
    done_d = 1'b0;
    kn = kfwd(rk_q, xt(rc_q));
    kp = kbwd(rk_q, rc_q);
    case (st_q)
      aes_idle:
        if (start_i)
        begin
          rk_d = key_i;
          blk_d = data_i;
          rc_d = RC_INIT;
          cnt_d = 4'h0;
          st_d = aes_kexp;
        end
      aes_kexp:
      begin
        rk_d = kn;
        rc_d = xt(rc_q);
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == 4'(`AES_ROUNDS - 1))
        begin
          blk_d = blk_q ^ kn;
          cnt_d = 4'(`AES_ROUNDS - 1);
          st_d = aes_round;
        end
      end
      aes_round:
      begin
        blk_d = iround(blk_q, kp, cnt_q == 4'h0);
        rk_d = kp;
        rc_d = (rc_q == 8'h1B) ? 8'h80 : {1'b0, rc_q[7:1]};
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h0)
        begin
          done_d = 1'b1;
          st_d = aes_idle;
        end
      end
      default: st_d = aes_idle;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      st_q <= aes_idle;
      cnt_q <= 4'h0;
      rc_q <= 8'h00;
      rk_q <= '0;
      blk_q <= '0;
      done_o <= 1'b0;
    end
    else if (ce_i)
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      rc_q <= rc_d;
      rk_q <= rk_d;
      blk_q <= blk_d;
      done_o <= done_d;
    end
  end

  assign busy_o = (st_q != aes_idle);
  assign data_o = blk_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  key_load_a: assert property (start_i && ce_i && !busy_o |=> rk_q == $past(key_i))
    else $error("key not taken from the stored key");
  round_end_a: assert property ($rose(done_o) |-> $past(st_q == aes_round && cnt_q == 4'h0))
    else $error("done without final round");
endmodule

// file: verif/jtag_prog_model.sv
// Purpose: Programmer model that drives the test-port link pins
// Assumes: The block samples the pins with its own fast clock
// Notes: Link clock stands still low between scans; idle data reads as one
`timescale 1ns/1ps
module jtag_prog_model
#(
  parameter int HALF_NS = 80
)
(
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  output logic trst_n_o,
  input wire logic tdo_i
);
  initial
  begin
    tck_o = 1'h0;
    tms_o = 1'h1;
    tdi_o = 1'h1;
    trst_n_o = 1'h1;
  end
  // One link cycle; output taken just before the rise, as the block samples it
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    tms_o = tms;
    tdi_o = tdi;
    #(HALF_NS);
    tdo = tdo_i;
    tck_o = 1'h1;
    #(HALF_NS);
    tck_o = 1'h0;
  endtask
  task automatic reset_tap();
    logic t;
    repeat (5) step(1'h1, 1'h1, t);
    step(1'h0, 1'h1, t);
  endtask
  task automatic pulse_trst();
    trst_n_o = 1'h0;
    #(4 * HALF_NS);
    trst_n_o = 1'h1;
    #(4 * HALF_NS);
  endtask
  // From idle through capture and shift back to idle; data least significant first
  task automatic scan(input bit ir, input int n, input logic [127:0] din, output logic [127:0] dout);
    logic t;
    dout = '0;
    step(1'h1, 1'h1, t);
    if (ir)
      step(1'h1, 1'h1, t);
    step(1'h0, 1'h1, t);
    step(1'h0, 1'h1, t);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], t);
      dout[i] = t;
    end
    step(1'h1, 1'h1, t);
    step(1'h0, 1'h1, t);
    tms_o = 1'h1;
    tdi_o = 1'h1;
  endtask
endmodule

// file: verif/tb_jtag_secure_programming_port.sv
// Purpose: Self-checking bench for the secure test-port programming block
// Assumes: The standard cipher known-answer block decrypts to a wrong tag
// Notes: No valid image can be built here without a forward cipher
`timescale 1ns/1ps
`include "jsp_params.svh"
module tb_jtag_secure_programming_port;
  logic clk_i, rst_n_i, osc_tick_i, io_in_i, user_tdo_i, pump_q, t, osc_run, strap, user_tdi_o;
  logic tck, tms, tdi, trst_n, tdo_o, tdo_oe_o, io_en_o, pump_clk_o, mem_wr_o;
  logic user_capture_o, user_shift_o, user_update_o;
  logic [1:0] mem_target_o;
  logic [15:0] mem_addr_o;
  logic [111:0] mem_wdata_o;
  logic [127:0] r, key;
  logic [3:0] ut;
  int n_fail, checked, cyc, n_wr, n_io, n_cap, n_sh, n_up, hi_len, lo_len, run;
  localparam logic [31:0] ID = {`ID_VERSION, `ID_PART, `ID_MAKER, 1'h1};
  jtag_secure_programming_port dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'h1), .tck_i(tck),
    .tms_i(tms), .tdi_i(tdi), .trst_n_i(trst_n), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
    .nv_key_i(key), .fabric_programmed_i(strap), .osc_run_i(osc_run), .osc_tick_i(osc_tick_i),
    .io_in_i(io_in_i), .user_tdo_i(user_tdo_i), .mem_rdata_i('0), .io_en_o(io_en_o),
    .pump_clk_o(pump_clk_o), .mem_wr_o(mem_wr_o), .mem_target_o(mem_target_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .user_tdi_o(user_tdi_o),
    .user_capture_o(user_capture_o), .user_shift_o(user_shift_o), .user_update_o(user_update_o));
  jtag_prog_model m (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n), .tdo_i(tdo_o));
  initial
  begin
    clk_i = 1'h0;
    forever #4 clk_i = ~clk_i;
  end
  // ----------------------------------------
  // Monitors and hang guard
  // ----------------------------------------
  always @(posedge clk_i)
  begin
    cyc++;
    osc_tick_i <= #1 ((cyc % 4) == 3);
    n_wr += (mem_wr_o === 1'h1);
    n_io += (io_en_o === 1'h1);
    n_cap += (user_capture_o === 1'h1);
    n_sh += (user_shift_o === 1'h1);
    n_up += (user_update_o === 1'h1);
    if (user_shift_o === 1'h1)
      ut = {user_tdi_o, ut[3:1]};
    if (pump_clk_o !== pump_q)
    begin
      if (pump_q === 1'h1)
        hi_len = run;
      else if (pump_q === 1'h0)
        lo_len = run;
      run = 1;
    end
    else
      run++;
    pump_q = pump_clk_o;
    if (cyc == 60000)
    begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic load_ir(input logic [7:0] op);
    m.scan(1'h1, `IR_W, {120'h0, op}, r);
    check(r[7:0], `IR_CAPTURE);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_idle();
    check({tdo_o, tdo_oe_o, io_en_o, mem_wr_o, pump_clk_o}, 5'h10);
    m.step(1'h0, 1'h1, t);
    m.scan(1'h0, 32, '0, r);
    check(r[31:0], ID);
  endtask
  task automatic t_trst();
    load_ir(`OP_BYPASS);
    m.pulse_trst();
    m.step(1'h0, 1'h1, t);
    m.scan(1'h0, 32, '0, r);
    check(r[31:0], ID);
  endtask
  task automatic t_tms_reset();
    load_ir(`OP_BYPASS);
    m.reset_tap();
    m.scan(1'h0, 32, '0, r);
    check(r[31:0], ID);
  endtask
  task automatic t_bypass();
    load_ir(`OP_BYPASS);
    m.scan(1'h0, 9, 128'hA5, r);
    check(r[8:0], 9'h14A);
  endtask
  task automatic t_sample();
    io_in_i = 1'h1;
    load_ir(`OP_SAMPLE);
    m.scan(1'h0, 1, 128'h1, r);
    check(r[0], 1'h0);
    check(n_io, 0);
  endtask
  task automatic t_user();
    user_tdo_i = 1'h1;
    load_ir(`OP_USER);
    {n_cap, n_sh, n_up} = '0;
    ut = '0;
    m.scan(1'h0, 4, 128'h5, r);
    check(r[3:0], 4'hF);
    check({n_cap[3:0], n_sh[3:0], n_up[3:0]}, 12'h141);
    check(ut, 4'h5);
    user_tdo_i = 1'h0;
  endtask
  task automatic t_bad_image();
    key = 128'h000102030405060708090A0B0C0D0E0F;
    load_ir(`OP_PROG_ROM);
    repeat (200) @(posedge clk_i);
    #1;
    check({hi_len[7:0], lo_len[7:0]}, 16'h080C);
    // Standard known-answer block: decrypts cleanly but carries a wrong tag
    m.scan(1'h0, 128, 128'h69C4E0D86A7B0430D8CDB78070B4C55A, r);
    check(r, '0);
    repeat (60) @(posedge clk_i);
    #1;
    check(dut_u.u_aes.data_o, 128'h00112233445566778899AABBCCDDEEFF);
    check(n_wr, 0);
    check({mem_addr_o, mem_wdata_o}, '0);
    check(mem_target_o, `TGT_ROM);
    load_ir(`OP_STATUS);
    m.scan(1'h0, `STAT_W, '0, r);
    check(r[7:0], 8'h02);
    check(n_io, 0);
  endtask
  task automatic t_osc_stop();
    load_ir(`OP_PROG_FLASH);
    osc_run = 1'h0;
    repeat (10) @(posedge clk_i);
    #1;
    check(pump_clk_o, 1'h0);
    check(mem_target_o, `TGT_FLASH);
    osc_run = 1'h1;
    load_ir(`OP_STATUS);
    m.scan(1'h0, `STAT_W, '0, r);
    check(r[7:0], 8'h08);
  endtask
  // Mid-run reset with the strap high: the device comes up programmed
  task automatic t_strap();
    strap = 1'h1;
    rst_n_i = 1'h0;
    repeat (5) @(posedge clk_i);
    #1 rst_n_i = 1'h1;
    repeat (5) @(posedge clk_i);
    #1;
    check(io_en_o, 1'h1);
    m.step(1'h0, 1'h1, t);
    load_ir(`OP_SAMPLE);
    m.scan(1'h0, 1, 128'h1, r);
    check(r[0], 1'h1);
    load_ir(`OP_PROG_FABRIC);
    check(io_en_o, 1'h0);
    load_ir(`OP_BYPASS);
    check(io_en_o, 1'h0);
  endtask
  initial
  begin
    {n_fail, checked, cyc, n_wr, n_io, n_cap, n_sh, n_up, hi_len, lo_len, run} = '0;
    {rst_n_i, osc_tick_i, io_in_i, user_tdo_i, pump_q, strap} = '0;
    osc_run = 1'h1;
    key = '0;
    ut = '0;
    repeat (5) @(posedge clk_i);
    #1 rst_n_i = 1'h1;
    repeat (5) @(posedge clk_i);
    #1;
    t_idle();
    t_trst();
    t_tms_reset();
    t_bypass();
    t_sample();
    t_user();
    t_bad_image();
    t_osc_stop();
    t_strap();
    wrap_up();
  end
endmodule
